// ==== core/adcrb_pkg.sv ====
/*
  Package for the converter result readback bank: register indices,
  reset values, bus widths and the sample carrier type.
  Assumes APB with 32-bit data; byte address is four times the index.
*/
package adcrb_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 14;
  // register indices
  localparam logic [IDX_W-1:0] IDX_CM_HIGH = 14'h05CC;
  localparam logic [IDX_W-1:0] IDX_CM_LOW = 14'h05CD;
  localparam logic [IDX_W-1:0] IDX_TRIM_HIGH = 14'h05D0;
  localparam logic [IDX_W-1:0] IDX_TRIM_LOW = 14'h05D1;
  localparam logic [IDX_W-1:0] IDX_PRI_HIGH = 14'h05D2;
  localparam logic [IDX_W-1:0] IDX_PRI_LOW = 14'h05D3;
  localparam logic [IDX_W-1:0] IDX_SEC_HIGH = 14'h05D4;
  localparam logic [IDX_W-1:0] IDX_SEC_LOW = 14'h05D5;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_CTRL = 14'h05D8;
  // reset values
  localparam logic [7:0] RST_HIGH = 8'h80;
  localparam logic [7:0] RST_LOW = 8'h00;
  localparam logic [15:0] RST_PAIR = {RST_HIGH, RST_LOW};
  localparam logic [1:0] RST_CAPTURE = 2'h3;
  // capture control field positions
  localparam int CAP_CM_BIT = 0;
  localparam int CAP_DIAG_BIT = 1;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } adcrb_sample_t;
endpackage

// ==== core/adcrb_bank.sv ====
/*
  Readback bank for converter results, read-only except capture control: common-mode voltage
  pair with a high-byte read lock, factory overvoltage DAC trim, and the
  primary/secondary values of the diagnostic converter comparison.
  Assumes APB3 master; sample inputs synchronous to pclk.
*/
// Added by the designer: the APB slave port.
//
// Behaviour
// - common-mode low byte readable, read-only
// - overvoltage trim readable as high/low bytes
// - primary diagnostic value readable as byte pair
// - secondary diagnostic value readable as byte pair
// - high-byte read freezes low byte until read
`timescale 1ns/1ns
module adcrb_bank
#(
  parameter logic [15:0] TRIM_DEFAULT = adcrb_pkg::RST_PAIR
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adcrb_pkg::ADDR_W-1:0] paddr,
  input wire logic [adcrb_pkg::DATA_W-1:0] pwdata,
  output logic [adcrb_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adcrb_pkg::adcrb_sample_t cm_sample,
  input wire adcrb_pkg::adcrb_sample_t trim_sample,
  input wire adcrb_pkg::adcrb_sample_t pri_sample,
  input wire adcrb_pkg::adcrb_sample_t sec_sample,
  output logic cm_lock
);

  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] common_mode_result_high;
  logic [7:0] common_mode_result_low;
  logic [15:0] overvoltage_reference_trim;
  logic [15:0] primary_diag_compare;
  logic [15:0] secondary_diag_compare;
  logic [1:0] capture_ctrl;
  logic [adcrb_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic done;
  logic rd_done;
  logic wr_done;
  logic cm_high_read;
  logic cm_low_read;
  logic cm_capture;
  logic diag_capture;

  assign idx = paddr[adcrb_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign done = psel & penable & pready;
  assign rd_done = done & ~pwrite & aligned;
  assign wr_done = done & pwrite & aligned;

  // completed reads of the common-mode pair and the capture gates
  assign cm_high_read = rd_done & (idx == adcrb_pkg::IDX_CM_HIGH);
  assign cm_low_read = rd_done & (idx == adcrb_pkg::IDX_CM_LOW);
  assign cm_capture = cm_sample.valid & capture_ctrl[adcrb_pkg::CAP_CM_BIT];
  assign diag_capture = capture_ctrl[adcrb_pkg::CAP_DIAG_BIT];

  ////////////////////////////////////////////////////////////////////////
  // readback decode
  function automatic logic [8:0] adcrb_read
  (
    input logic [adcrb_pkg::IDX_W-1:0] i,
    input logic [7:0] cmh,
    input logic [7:0] cml,
    input logic [15:0] trim,
    input logic [15:0] pri,
    input logic [15:0] sec,
    input logic [1:0] cap
  );
    // bit 8 flags a mapped index
    case (i)
      adcrb_pkg::IDX_CM_HIGH: adcrb_read = {1'b1, cmh};
      adcrb_pkg::IDX_CM_LOW: adcrb_read = {1'b1, cml};
      adcrb_pkg::IDX_TRIM_HIGH: adcrb_read = {1'b1, trim[15:8]};
      adcrb_pkg::IDX_TRIM_LOW: adcrb_read = {1'b1, trim[7:0]};
      adcrb_pkg::IDX_PRI_HIGH: adcrb_read = {1'b1, pri[15:8]};
      adcrb_pkg::IDX_PRI_LOW: adcrb_read = {1'b1, pri[7:0]};
      adcrb_pkg::IDX_SEC_HIGH: adcrb_read = {1'b1, sec[15:8]};
      adcrb_pkg::IDX_SEC_LOW: adcrb_read = {1'b1, sec[7:0]};
      adcrb_pkg::IDX_CAPTURE_CTRL: adcrb_read = {1'b1, 6'h00, cap};
      default: adcrb_read = 9'h000;
    endcase
  endfunction

  logic [8:0] rd_word;
  assign rd_word = adcrb_read(idx, common_mode_result_high,
    common_mode_result_low, overvoltage_reference_trim,
    primary_diag_compare, secondary_diag_compare, capture_ctrl);

  ////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, then pready for one cycle
  logic access_wait;
  logic refused;
  logic [adcrb_pkg::DATA_W-1:0] next_prdata;
  logic next_pslverr;

  assign access_wait = psel & penable & ~pready;

  // writes only reach the capture control register
  always_comb
  begin
    refused = 1'b0;
    if (!aligned)
      refused = 1'b1;
    else if (!rd_word[8])
      refused = 1'b1;
    else if (pwrite && idx != adcrb_pkg::IDX_CAPTURE_CTRL)
      refused = 1'b1;
  end

  // refused or write access answers with zero data
  always_comb
  begin
    next_prdata = 32'h00000000;
    next_pslverr = refused;
    if (!pwrite && !refused)
      next_prdata = {24'h000000, rd_word[7:0]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= access_wait;
  end

  // data holds after the answer, the error flag does not
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (access_wait)
    begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
    else
      pslverr <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // capture control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_ctrl <= adcrb_pkg::RST_CAPTURE;
    else if (wr_done && idx == adcrb_pkg::IDX_CAPTURE_CTRL)
      capture_ctrl <= pwdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // common-mode pair with read lock
  // lock runs from high-byte read to low-byte read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cm_lock <= 1'b0;
    else if (cm_high_read)
      cm_lock <= 1'b1;
    else if (cm_low_read)
      cm_lock <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      common_mode_result_high <= adcrb_pkg::RST_HIGH;
      common_mode_result_low <= adcrb_pkg::RST_LOW;
    end
    else if (cm_capture)
    begin
      common_mode_result_high <= cm_sample.value[15:8];
      // high byte keeps tracking, only the low byte freezes
      if (!cm_lock)
        common_mode_result_low <= cm_sample.value[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // factory trim
  // trim loads regardless of the capture gates
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overvoltage_reference_trim <= TRIM_DEFAULT;
    else if (trim_sample.valid)
      overvoltage_reference_trim <= trim_sample.value;
  end

  ////////////////////////////////////////////////////////////////////////
  // diagnostic comparison values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      primary_diag_compare <= adcrb_pkg::RST_PAIR;
    else if (pri_sample.valid && diag_capture)
      primary_diag_compare <= pri_sample.value;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      secondary_diag_compare <= adcrb_pkg::RST_PAIR;
    else if (sec_sample.valid && diag_capture)
      secondary_diag_compare <= sec_sample.value;
  end

endmodule

// ==== test/adcrb_chk_sva.sv ====
/* assertions on the readback bank ports
   assumes an APB master that holds each request until pready */
`timescale 1ns/1ns
module adcrb_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cm_lock
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [13:0] i = paddr[15:2];
  wire rd = pready && !pwrite && !pslverr;
  AST_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  AST_BYTE: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("answer stood longer than one cycle");
  AST_RO: assert property (pready && pwrite && i != 14'h05D8 |-> pslverr)
    else $error("write to read-only register accepted");
  AST_MAP: assert property (pready && !pwrite && paddr[1:0] == 2'h0
    && i >= 14'h05D0 && i <= 14'h05D5 |-> !pslverr)
    else $error("mapped read refused");
  AST_LOCK: assert property (rd && i == 14'h05CC |=> cm_lock)
    else $error("high byte read did not lock");
  AST_FREE: assert property (rd && i == 14'h05CD |=> !cm_lock)
    else $error("low byte read did not unlock");
endmodule
bind adcrb_bank adcrb_chk u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .cm_lock(cm_lock)
);

// ==== test/testbench.sv ====
/* self-checking bench for the readback bank
   drives APB and the sample inputs directly */
`timescale 1ns/1ns
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, cm_lock, e;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [15:0] v [4];
  logic [7:0] old, hi;
  logic [1:0] lane = 2'h0;
  adcrb_pkg::adcrb_sample_t cm_sample = '0, trim_sample = '0;
  adcrb_pkg::adcrb_sample_t pri_sample = '0, sec_sample = '0;
  int errors = 0, n_checks = 0, cyc = 0;
  adcrb_bank DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cm_sample(cm_sample),
    .trim_sample(trim_sample),
    .pri_sample(pri_sample),
    .sec_sample(sec_sample),
    .cm_lock(cm_lock)
  );
  always #4 pclk = ~pclk;
  function automatic logic [13:0] idx(input int k);
    return k < 2 ? 14'h05CC + k : 14'h05CE + k;
  endfunction
  task chk(input string n, input logic [31:0] x, y);
    n_checks++;
    if (x !== y)
    begin
      errors++;
      $display("unexpected %s exp %h got %h", n, x, y);
    end
  endtask
  task rw(input logic [13:0] i, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, lane};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ld(input logic [15:0] a, b, c, x);
    @(posedge pclk);
    cm_sample <= {1'b1, a};
    trim_sample <= {1'b1, b};
    pri_sample <= {1'b1, c};
    sec_sample <= {1'b1, x};
    v = '{a, b, c, x};
    @(posedge pclk);
    cm_sample.valid <= 1'b0;
    trim_sample.valid <= 1'b0;
    pri_sample.valid <= 1'b0;
    sec_sample.valid <= 1'b0;
  endtask
  task t_rst;
    chk("lock at reset", 32'h0, {31'h0, cm_lock});
    for (int k = 0; k < 8; k++)
    begin
      rw(idx(k), 1'b0, 32'h0);
      chk("reset value", k[0] ? 32'h0 : 32'h80, d);
    end
    rw(14'h05D8, 1'b0, 32'h0);
    chk("capture reset", 32'h3, d);
    $display("reset test done");
  endtask
  task t_load;
    ld(16'hA51C, 16'h7E3D, 16'hC2F4, 16'h19B6);
    for (int k = 0; k < 4; k++)
    begin
      rw(idx(2 * k), 1'b0, 32'h0);
      hi = d[7:0];
      chk("high byte", {24'h0, v[k][15:8]}, d);
      rw(idx(2 * k + 1), 1'b0, 32'h0);
      chk("low byte", {24'h0, v[k][7:0]}, d);
      chk("joined pair", {16'h0, v[k]}, {16'h0, hi, d[7:0]});
    end
    $display("load test done");
  endtask
  task t_lock;
    old = v[0][7:0];
    rw(14'h05CC, 1'b0, 32'h0);
    @(posedge pclk);
    chk("lock set", 32'h1, {31'h0, cm_lock});
    ld(16'h3C96, 16'h7E3D, 16'hC2F4, 16'h19B6);
    rw(14'h05CC, 1'b0, 32'h0);
    chk("cm high", 32'h3C, d);
    rw(14'h05CD, 1'b0, 32'h0);
    chk("cm low held", {24'h0, old}, d);
    @(posedge pclk);
    chk("lock free", 32'h0, {31'h0, cm_lock});
    ld(16'h3C96, 16'h7E3D, 16'hC2F4, 16'h19B6);
    rw(14'h05CD, 1'b0, 32'h0);
    chk("cm low free", 32'h96, d);
    $display("lock test done");
  endtask
  task t_cap;
    rw(14'h05D8, 1'b1, 32'hFFFFFFFC);
    chk("capture write", 32'h0, {31'h0, e});
    rw(14'h05D8, 1'b0, 32'h0);
    chk("capture read", 32'h0, d);
    ld(16'h5AA5, 16'h1234, 16'h6789, 16'hBCDE);
    rw(14'h05CD, 1'b0, 32'h0);
    chk("cm gated", 32'h96, d);
    rw(14'h05D1, 1'b0, 32'h0);
    chk("trim ungated", 32'h34, d);
    rw(14'h05D2, 1'b0, 32'h0);
    chk("primary gated", 32'hC2, d);
    rw(14'h05D5, 1'b0, 32'h0);
    chk("secondary gated", 32'hB6, d);
    rw(14'h05D8, 1'b1, 32'h3);
    rw(14'h05D8, 1'b0, 32'h0);
    chk("capture restored", 32'h3, d);
    $display("capture test done");
  endtask
  task t_err;
    rw(14'h05CD, 1'b1, 32'hFF);
    chk("write refused", 32'h1, {31'h0, e});
    rw(14'h05CD, 1'b0, 32'h0);
    chk("low kept", 32'h96, d);
    rw(14'h05CE, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    lane = 2'h2;
    rw(14'h05D2, 1'b0, 32'h0);
    lane = 2'h0;
    chk("unaligned", 32'h1, {31'h0, e});
    chk("refused data", 32'h0, d);
    $display("error test done");
  endtask
  task t_mid;
    rw(14'h05CC, 1'b0, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("lock in reset", 32'h0, {31'h0, cm_lock});
    presetn <= 1'b1;
    t_rst;
    $display("mid reset test done");
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_rst;
    t_load;
    t_lock;
    t_cap;
    t_err;
    t_mid;
    test_done;
  end
endmodule
